// >>> chip_select_map.svh
// register offsets, field positions and reset values of the chip select decoder
// assumes the includer addresses the registers as aligned 32-bit APB words
`ifndef CHIP_SELECT_MAP_SVH
`define CHIP_SELECT_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SELECT_CONTROL 5'h00
`define OFS_MAP_SIZE 5'h04
`define OFS_GP1_BASE 5'h08
`define OFS_GP1_CONTROL 5'h0c
`define OFS_GP2_BASE 5'h10
`define OFS_GP2_CONTROL 5'h14
`define OFS_STRETCH 5'h18
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SELECT_CONTROL 8'h04
`define RST_ZERO 8'h00
// ----------------------------------------
// select_control fields
// ----------------------------------------
`define BIT_PROG_SIZE_LO 0
`define BIT_PROG_SIZE_HI 1
`define BIT_PROG_ENABLE 2
`define BIT_PRIORITY 3
`define BIT_IO_SIZE 4
`define BIT_IO_VALID 5
`define BIT_IO_POLARITY 6
`define BIT_IO_ENABLE 7
// ----------------------------------------
// map size, general control and stretch fields
// ----------------------------------------
`define BIT_GP1_SOURCE 0
`define BIT_GP2_SOURCE 1
`define BIT_GP_VALID 4
`define BIT_GP_POLARITY 5
`define BIT_GP_DRIVES_PROG 6
`define BIT_GP1_DRIVES_TWO 7
`define GP_CTRL2_MASK 8'h7f
`define MAP_SIZE_MASK 8'h03
`define LSB_STRETCH_PROG 0
`define LSB_STRETCH_GP2 2
`define LSB_STRETCH_GP1 4
`define LSB_STRETCH_IO 6
// ----------------------------------------
// general size codes
// ----------------------------------------
`define GP_SIZE_OFF 4'h0
`define GP_SIZE_WIN1 4'ha
`define GP_SIZE_WIN2 4'hb
`define GP_SIZE_CLAMP 4'hc
`define GP_BOUND_BASE 5'h0a
`define GP_BOUND_MAX 5'h13
`endif

// >>> chip_select_pkg.sv
// types shared by the chip select decoder
// assumes chip_select_map.svh supplies the numbers
package chip_select_pkg;
	typedef logic [7:0] reg8_t; // one 8-bit register
	typedef logic [1:0] stretch_t; // extra bus cycles
	typedef logic [3:0] gp_size_t; // general size code
endpackage : chip_select_pkg

// >>> chip_select_decoder.sv
// chip select decoder: four external selects with an APB register file
// assumes cpu/expansion address, e clock level, address valid, bus tick and
// mode come from logic on pclk; the port pin muxes sit outside
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "chip_select_map.svh"
module chip_select_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] cpu_addr, // cpu bus address
	input wire logic [18:0] exp_addr, // expansion address
	input wire logic window1_hit, // cpu address in window 1
	input wire logic window2_hit, // cpu address in window 2
	input wire logic e_clock_high, // e clock high phase
	input wire logic address_valid, // address valid phase
	input wire logic bus_tick, // one pulse per bus cycle end
	input wire logic expanded_mode, // expanded operating mode
	output logic program_select, // pin level
	output logic program_select_oe, // port H bit 7 taken
	output logic io_select,
	output logic io_select_oe, // port H bit 4 taken
	output logic general_select_one,
	output logic general_select_one_oe,
	output logic general_select_two,
	output logic general_select_two_oe,
	output logic e_hold // keep e high this cycle
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	chip_select_pkg::reg8_t select_control;
	chip_select_pkg::reg8_t map_size_select;
	chip_select_pkg::reg8_t gp1_base_address;
	chip_select_pkg::reg8_t gp1_control;
	chip_select_pkg::reg8_t gp2_base_address;
	chip_select_pkg::reg8_t gp2_control;
	chip_select_pkg::reg8_t stretch_select_reg;

	// ----------------------------------------
	// field views
	// ----------------------------------------
	wire logic [1:0] program_size = {select_control[`BIT_PROG_SIZE_HI],
		select_control[`BIT_PROG_SIZE_LO]};
	wire logic program_select_enable = select_control[`BIT_PROG_ENABLE];
	wire logic general_priority = select_control[`BIT_PRIORITY];
	wire logic io_select_size = select_control[`BIT_IO_SIZE];
	wire logic io_select_valid_time = select_control[`BIT_IO_VALID];
	wire logic io_select_polarity = select_control[`BIT_IO_POLARITY];
	wire logic io_select_enable = select_control[`BIT_IO_ENABLE];
	wire logic general_one_source = map_size_select[`BIT_GP1_SOURCE];
	wire logic general_two_source = map_size_select[`BIT_GP2_SOURCE];
	wire chip_select_pkg::gp_size_t general_one_size = gp1_control[3:0];
	wire chip_select_pkg::gp_size_t general_two_size = gp2_control[3:0];
	wire logic general_one_valid_time = gp1_control[`BIT_GP_VALID];
	wire logic general_two_valid_time = gp2_control[`BIT_GP_VALID];
	wire logic general_one_polarity = gp1_control[`BIT_GP_POLARITY];
	wire logic general_two_polarity = gp2_control[`BIT_GP_POLARITY];
	wire logic general_one_drives_program = gp1_control[`BIT_GP_DRIVES_PROG];
	wire logic general_two_drives_program = gp2_control[`BIT_GP_DRIVES_PROG];
	wire logic general_one_drives_two = gp1_control[`BIT_GP1_DRIVES_TWO];

	// ----------------------------------------
	// general range compare
	// ----------------------------------------
	// base bit j stands for address bit 11+j; bits below the size boundary
	// and, on cpu addressing, bits above 15 take no part
	function automatic logic gp_match(
		input chip_select_pkg::gp_size_t size,
		input logic src,
		input chip_select_pkg::reg8_t base,
		input logic [15:0] caddr,
		input logic [18:0] xaddr,
		input logic w1,
		input logic w2
	);
		logic [18:0] a;
		logic [4:0] bound;
		logic hit;
		integer j;
		a = src ? xaddr : {3'h0, caddr};
		// codes from the clamp upward act as the largest size
		bound = (size >= `GP_SIZE_CLAMP) ? `GP_BOUND_MAX :
			`GP_BOUND_BASE + {1'b0, size};
		hit = 1'b1;
		for (j = 0; j < 8; j = j + 1)
		begin
			if ((11 + j >= bound) && (src || j <= 4) && (a[11 + j] != base[j]))
				hit = 1'b0;
		end
		if (size == `GP_SIZE_OFF)
			hit = 1'b0;
		else if (size == `GP_SIZE_WIN1)
			hit = w1;
		else if (size == `GP_SIZE_WIN2)
			hit = w2;
		return hit;
	endfunction : gp_match

	// ----------------------------------------
	// raw range hits
	// ----------------------------------------
	// every hit is gated by the operating mode
	wire logic prog_range = (program_size == 2'h0) ||
		(program_size == 2'h1 && cpu_addr[15]) ||
		(program_size == 2'h2 && cpu_addr[15:14] == 2'h3) ||
		(program_size == 2'h3 && cpu_addr[15:13] == 3'h7);
	wire logic prog_hit = expanded_mode && program_select_enable && prog_range;
	wire logic io_range = (cpu_addr[15:13] == 3'h0) &&
		(io_select_size || cpu_addr[12]);
	wire logic io_hit = expanded_mode && io_select_enable && io_range;
	wire logic g1_hit = expanded_mode && gp_match(general_one_size, general_one_source,
		gp1_base_address, cpu_addr, exp_addr, window1_hit, window2_hit);
	wire logic g2_hit = expanded_mode && gp_match(general_two_size, general_two_source,
		gp2_base_address, cpu_addr, exp_addr, window1_hit, window2_hit);

	// ----------------------------------------
	// priority between program and general
	// ----------------------------------------
	// the loser of a contested address is dropped so program and the general selects never fire together
	wire logic contested = prog_hit && (g1_hit || g2_hit);
	wire logic prog_win = prog_hit && !(contested && general_priority);
	wire logic g1_win = g1_hit && !(prog_hit && !general_priority);
	wire logic g2_win = g2_hit && !(prog_hit && !general_priority);

	// ----------------------------------------
	// timing windows
	// ----------------------------------------
	wire logic prog_time = address_valid;
	wire logic io_time = address_valid &&
		(io_select_valid_time || e_clock_high);
	wire logic g1_time = address_valid &&
		(general_one_valid_time || e_clock_high);
	wire logic g2_time = address_valid &&
		(general_two_valid_time || e_clock_high);
	wire logic prog_on = prog_win && prog_time;
	wire logic io_on = io_hit && io_time;
	wire logic g1_on = g1_win && g1_time;
	wire logic g2_on = g2_win && g2_time;

	// ----------------------------------------
	// one select driving another
	// ----------------------------------------
	// driving the program pin takes precedence, and a general two that
	// drives the program pin has no own pin left for general one to use
	wire logic g1_to_two = general_one_drives_two && !general_one_drives_program &&
		!general_two_drives_program;
	wire logic prog_drive = prog_on || (general_one_drives_program && g1_on) ||
		(general_two_drives_program && g2_on);
	wire logic g2_drive = !general_two_drives_program &&
		(g2_on || (g1_to_two && g1_on));
	wire logic g1_drive = !general_one_drives_program && !g1_to_two && g1_on;

	// ----------------------------------------
	// stretch selection
	// ----------------------------------------
	// one access sits in one range when ranges do not overlap; the order
	// below only settles overlapping setups
	wire logic stretch_hit = io_hit || prog_win || g1_win || g2_win;
	wire chip_select_pkg::stretch_t stretch_val = io_hit ?
		stretch_select_reg[`LSB_STRETCH_IO +: 2] : prog_win ?
		stretch_select_reg[`LSB_STRETCH_PROG +: 2] : g1_win ?
		stretch_select_reg[`LSB_STRETCH_GP1 +: 2] :
		stretch_select_reg[`LSB_STRETCH_GP2 +: 2];
	chip_select_pkg::stretch_t stretch_left; // extra cycles still to run
	wire logic stretch_load = bus_tick && stretch_left == 2'h0 &&
		stretch_hit && stretch_val != 2'h0;
	wire logic stretch_step = bus_tick && stretch_left != 2'h0;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic [4:0] ofs = paddr[4:0];
	wire logic mapped = (paddr[31:5] == 27'h0) && (ofs[1:0] == 2'h0) &&
		(ofs <= `OFS_STRETCH);
	wire logic access = psel && penable && !pready; // first access cycle
	wire logic wr_done = psel && penable && pready && pwrite && mapped;
	wire chip_select_pkg::reg8_t wbyte = pwdata[7:0];
	wire chip_select_pkg::reg8_t rbyte =
		(ofs == `OFS_SELECT_CONTROL) ? select_control :
		(ofs == `OFS_MAP_SIZE) ? map_size_select :
		(ofs == `OFS_GP1_BASE) ? gp1_base_address :
		(ofs == `OFS_GP1_CONTROL) ? gp1_control :
		(ofs == `OFS_GP2_BASE) ? gp2_base_address :
		(ofs == `OFS_GP2_CONTROL) ? gp2_control :
		(ofs == `OFS_STRETCH) ? stretch_select_reg : `RST_ZERO;

	// ----------------------------------------
	// apb handshake: one wait state per access
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= access; // answer in the next cycle
			pslverr <= access && !mapped;
			prdata <= (access && !pwrite) ? {24'h0, rbyte} : 32'h0;
		end
	end

	// ----------------------------------------
	// register writes, taken at the completing edge
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			select_control <= `RST_SELECT_CONTROL;
			map_size_select <= `RST_ZERO;
			gp1_base_address <= `RST_ZERO;
			gp1_control <= `RST_ZERO;
			gp2_base_address <= `RST_ZERO;
			gp2_control <= `RST_ZERO;
			stretch_select_reg <= `RST_ZERO;
		end
		else if (wr_done)
		begin
			// unused bits are kept at zero so they read back as zero
			if (ofs == `OFS_SELECT_CONTROL)
				select_control <= wbyte;
			if (ofs == `OFS_MAP_SIZE)
				map_size_select <= wbyte & `MAP_SIZE_MASK;
			if (ofs == `OFS_GP1_BASE)
				gp1_base_address <= wbyte;
			if (ofs == `OFS_GP1_CONTROL)
				gp1_control <= wbyte;
			if (ofs == `OFS_GP2_BASE)
				gp2_base_address <= wbyte;
			if (ofs == `OFS_GP2_CONTROL)
				gp2_control <= wbyte & `GP_CTRL2_MASK;
			if (ofs == `OFS_STRETCH)
				stretch_select_reg <= wbyte;
		end
	end

	// ----------------------------------------
	// select pins, polarity applied last
	// ----------------------------------------
	// pins are registered so they lag the address by one pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			program_select <= 1'b1;
			io_select <= 1'b1;
			general_select_one <= 1'b1;
			general_select_two <= 1'b1;
			program_select_oe <= 1'b0;
			io_select_oe <= 1'b0;
			general_select_one_oe <= 1'b0;
			general_select_two_oe <= 1'b0;
		end
		else
		begin
			program_select <= !prog_drive;
			io_select <= io_on ~^ io_select_polarity;
			general_select_one <= g1_drive ~^ general_one_polarity;
			general_select_two <= g2_drive ~^ general_two_polarity;
			program_select_oe <= program_select_enable;
			io_select_oe <= io_select_enable;
			general_select_one_oe <= general_one_size != `GP_SIZE_OFF;
			general_select_two_oe <= general_two_size != `GP_SIZE_OFF;
		end
	end

	// ----------------------------------------
	// e clock stretch
	// ----------------------------------------
	// only e is held; pclk and every timer on it keep running
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stretch_left <= 2'h0;
			e_hold <= 1'b0;
		end
		else if (stretch_load)
		begin
			stretch_left <= stretch_val;
			e_hold <= 1'b1;
		end
		else if (stretch_step)
		begin
			stretch_left <= stretch_left - 2'h1;
			e_hold <= stretch_left != 2'h1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_load;
		stretch_load ##1 e_hold;
	endsequence
	sequence s_contest_prog;
		prog_hit && (g1_hit || g2_hit) && !general_priority;
	endsequence

	chk_prog_low_fixed: assert property (
		prog_on |=> !program_select) else $error("program select not low");
	chk_prog_priority: assert property (
		s_contest_prog |-> !g1_win && !g2_win) else $error("program lost priority");
	chk_gp_priority: assert property (
		contested && general_priority |-> !prog_win) else $error("two selects on contest");
	chk_io_range_time: assert property (
		io_on |-> cpu_addr[15:13] == 3'h0 && (io_select_size || cpu_addr[12]) &&
		(io_select_valid_time || e_clock_high)) else $error("io select out of range");
	chk_mode_gate: assert property (
		!expanded_mode |=> program_select && (general_select_one ^ general_one_polarity))
		else $error("select fired outside expanded mode");
	chk_gp_polarity: assert property (
		g1_drive |=> general_select_one == $past(general_one_polarity))
		else $error("general one level wrong");
	chk_window_follow: assert property (
		expanded_mode && general_one_size == `GP_SIZE_WIN1 |-> g1_hit == window1_hit)
		else $error("window follow broken");
	chk_drive_silent: assert property (
		general_one_drives_program ##1 general_one_drives_program |->
		general_select_one != general_one_polarity) else $error("driver pin asserted");
	chk_gp_off: assert property (
		general_two_size == `GP_SIZE_OFF |-> !g2_hit) else $error("disabled select hit");
	chk_stretch_len: assert property (
		s_load |-> stretch_left == $past(stretch_val)) else $error("stretch count wrong");
	chk_stretch_hold: assert property (
		e_hold |-> stretch_left != 2'h0) else $error("e held with no count");
	chk_apb_answer: assert property (
		access |=> pready ##1 !pready) else $error("apb answer timing");
endmodule : chip_select_decoder

// >>> ext_devices.sv
// far side of the decoder: four external devices, each enabled by one select pin
// assumes the bench tells it the active level that software programmed for the io select and both general selects
`timescale 1ns/100ps
module ext_devices (
	input wire logic program_select,
	input wire logic io_select,
	input wire logic general_select_one,
	input wire logic general_select_two,
	input wire logic io_level, // active level of the io select
	input wire logic gp1_level, // active level of general select one
	input wire logic gp2_level, // active level of general select two
	output logic [3:0] enabled // program, io, general one, general two
);
	// ----------------------------------------
	// device enables
	// ----------------------------------------
	// program memory is wired for an active-low select, it has no other choice
	assign enabled[3] = !program_select;
	// an unknown pin level stays unknown here, so it never reads as a clean enable
	assign enabled[2] = io_select == io_level;
	assign enabled[1] = general_select_one == gp1_level;
	assign enabled[0] = general_select_two == gp2_level;
endmodule : ext_devices

// >>> test_external_chip_select_decoder.sv
// self-checking bench of the chip select decoder
// assumes the decoder answers apb before the watchdog ends the run and decodes with one cycle latency
`timescale 1ns/100ps
`include "chip_select_map.svh"
module test_external_chip_select_decoder;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e;
	logic [15:0] cpu_addr = 16'h0; // cpu bus address
	logic [18:0] exp_addr = 19'h0; // expansion address
	logic window1_hit = 1'b0, window2_hit = 1'b0, e_clock_high = 1'b1;
	logic address_valid = 1'b1, bus_tick = 1'b0, expanded_mode = 1'b1;
	logic program_select, program_select_oe, io_select, io_select_oe, e_hold;
	logic general_select_one, general_select_one_oe, general_select_two, general_select_two_oe;
	logic io_level = 1'b0, gp1_level = 1'b0, gp2_level = 1'b0; // programmed levels
	logic [3:0] enabled; // which devices see their select active
	int failures = 0, n_compared = 0;
	// 40 mhz bus clock
	always #12.5 pclk = !pclk;
	chip_select_decoder i_chip_select_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr), .exp_addr(exp_addr),
		.window1_hit(window1_hit), .window2_hit(window2_hit), .e_clock_high(e_clock_high),
		.address_valid(address_valid), .bus_tick(bus_tick), .expanded_mode(expanded_mode),
		.program_select(program_select), .program_select_oe(program_select_oe),
		.io_select(io_select), .io_select_oe(io_select_oe),
		.general_select_one(general_select_one), .general_select_one_oe(general_select_one_oe),
		.general_select_two(general_select_two), .general_select_two_oe(general_select_two_oe),
		.e_hold(e_hold));
	ext_devices i_ext_devices (.program_select(program_select), .io_select(io_select),
		.general_select_one(general_select_one), .general_select_two(general_select_two),
		.io_level(io_level), .gp1_level(gp1_level), .gp2_level(gp2_level), .enabled(enabled));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	// one apb transfer; the request stands until pready is seen high at an edge
	task apb(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {27'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count is assumed here; only the watchdog ends a hung access
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		check({31'h0, pready}, 32'h1, "apb answer");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// drive one bus address, then let the one-cycle decode latency pass
	task bus(input logic [15:0] ca, input logic [18:0] xa, input logic [2:0] weh);
		@(posedge pclk);
		cpu_addr <= ca;
		exp_addr <= xa;
		{window1_hit, window2_hit, e_clock_high} <= weh;
		repeat (2) @(posedge pclk);
		#1;
	endtask : bus
	task sel(input logic [3:0] exp, input string msg);
		check({28'h0, enabled}, {28'h0, exp}, msg);
	endtask : sel
	task tick(input logic exp);
		@(posedge pclk);
		bus_tick <= 1'b1;
		@(posedge pclk);
		bus_tick <= 1'b0;
		#1;
		check({31'h0, e_hold}, {31'h0, exp}, "stretch hold");
	endtask : tick
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task test_reset;
		check({28'h0, program_select_oe, io_select_oe, general_select_one_oe,
			general_select_two_oe}, 32'h8, "pin ownership at reset");
		apb(1'b0, `OFS_SELECT_CONTROL, 8'h0);
		check(r, 32'h4, "control reset");
		apb(1'b0, `OFS_STRETCH, 8'h0);
		check(r, 32'h0, "stretch reset");
		apb(1'b1, `OFS_GP2_CONTROL, 8'hff);
		apb(1'b0, `OFS_GP2_CONTROL, 8'h0);
		check(r, 32'h7f, "gp2 control readback");
		apb(1'b0, 5'h1c, 8'h0);
		check({r[30:0], e}, 32'h1, "unmapped read");
		apb(1'b1, `OFS_GP2_CONTROL, 8'h00);
		$display("test reset done");
	endtask : test_reset
	task test_program;
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, `OFS_SELECT_CONTROL, 8'h04 | 8'(c));
			bus(16'((17'h10000 - (17'h10000 >> c))), 19'h0, 3'b001);
			sel(4'h8, "program range low end");
			if (c != 0)
			begin
				bus(16'((17'hffff - (17'h10000 >> c))), 19'h0, 3'b001);
				sel(4'h0, "below program range");
			end
		end
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h00);
		bus(16'hffff, 19'h0, 3'b001);
		sel(4'h0, "program disabled");
		check({31'h0, program_select_oe}, 32'h0, "program pin released");
		$display("test program done");
	endtask : test_program
	task test_io;
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h80);
		bus(16'h1000, 19'h0, 3'b001);
		sel(4'h4, "io 4k start");
		check({31'h0, io_select_oe}, 32'h1, "io pin taken");
		bus(16'h0fff, 19'h0, 3'b001);
		sel(4'h0, "below io 4k");
		bus(16'h1000, 19'h0, 3'b000);
		sel(4'h0, "io outside e high");
		apb(1'b1, `OFS_SELECT_CONTROL, 8'hf0);
		io_level = 1'b1;
		bus(16'h0000, 19'h0, 3'b000);
		sel(4'h4, "io 8k, address valid");
		check({31'h0, io_select}, 32'h1, "io active high");
		bus(16'h2000, 19'h0, 3'b001);
		sel(4'h0, "above io 8k");
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h00);
		io_level = 1'b0; // back to the reset level of the io select
		$display("test io done");
	endtask : test_io
	task test_general;
		apb(1'b1, `OFS_GP1_BASE, 8'h0b);
		apb(1'b1, `OFS_GP1_CONTROL, 8'h03);
		bus(16'h5fff, 19'h0, 3'b001);
		sel(4'h2, "gp1 8k cpu, low base bits ignored");
		bus(16'h6000, 19'h0, 3'b001);
		sel(4'h0, "outside gp1 8k");
		bus(16'h4000, 19'h0, 3'b000);
		sel(4'h0, "gp1 outside e high");
		apb(1'b1, `OFS_MAP_SIZE, 8'h01);
		apb(1'b1, `OFS_GP1_BASE, 8'h81);
		apb(1'b1, `OFS_GP1_CONTROL, 8'h31);
		gp1_level = 1'b1;
		bus(16'h0, 19'h40800, 3'b000);
		sel(4'h2, "gp1 2k expansion");
		bus(16'h0800, 19'h40000, 3'b000);
		sel(4'h0, "outside gp1 2k expansion");
		apb(1'b1, `OFS_GP1_CONTROL, 8'h3c);
		bus(16'h0, 19'h00000, 3'b000);
		sel(4'h2, "size clamp to 512k");
		apb(1'b1, `OFS_GP1_CONTROL, 8'h30);
		// the pin ownership flop follows the size code one edge after the write
		@(posedge pclk);
		#1;
		check({31'h0, general_select_one_oe}, 32'h0, "gp1 off releases pin");
		gp2_level = 1'b1;
		for (int w = 0; w < 2; w++)
		begin
			apb(1'b1, `OFS_GP2_CONTROL, 8'h3a + 8'(w));
			bus(16'h0, 19'h0, w == 0 ? 3'b100 : 3'b010);
			sel(4'h1, "follows window");
			bus(16'h0, 19'h0, 3'b001);
			sel(4'h0, "outside window");
		end
		apb(1'b1, `OFS_GP2_CONTROL, 8'h00);
		apb(1'b1, `OFS_MAP_SIZE, 8'h00);
		{gp1_level, gp2_level} = 2'b00;
		$display("test general done");
	endtask : test_general
	task test_priority;
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h04);
		apb(1'b1, `OFS_GP1_BASE, 8'h08);
		apb(1'b1, `OFS_GP1_CONTROL, 8'h03);
		bus(16'h4000, 19'h0, 3'b001);
		sel(4'h8, "program wins");
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h0c);
		bus(16'h4000, 19'h0, 3'b001);
		sel(4'h2, "general wins");
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h07);
		apb(1'b1, `OFS_GP1_CONTROL, 8'h43);
		bus(16'h4000, 19'h0, 3'b001);
		sel(4'h8, "gp1 drives program pin");
		apb(1'b1, `OFS_GP2_BASE, 8'h10);
		apb(1'b1, `OFS_GP2_CONTROL, 8'h01);
		apb(1'b1, `OFS_GP1_CONTROL, 8'h83);
		bus(16'h4000, 19'h0, 3'b001);
		sel(4'h1, "gp1 drives gp2 pin");
		bus(16'h8000, 19'h0, 3'b001);
		sel(4'h1, "gp2 own range");
		apb(1'b1, `OFS_GP1_CONTROL, 8'h00);
		apb(1'b1, `OFS_GP2_CONTROL, 8'h00);
		$display("test priority done");
	endtask : test_priority
	task test_stretch;
		apb(1'b1, `OFS_SELECT_CONTROL, 8'h04);
		apb(1'b1, `OFS_STRETCH, 8'h02 << `LSB_STRETCH_PROG);
		bus(16'he000, 19'h0, 3'b001);
		tick(1'b1);
		tick(1'b1);
		tick(1'b0);
		bus(16'he000, 19'h0, 3'b001);
		@(posedge pclk);
		expanded_mode <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		sel(4'h0, "single chip mode");
		$display("test stretch and mode done");
	endtask : test_stretch
	// ----------------------------------------
	// closing and main sequence
	// ----------------------------------------
	task report_and_stop;
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// a hang in an apb wait is cut short well beyond the few hundred cycles of the run
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		report_and_stop();
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		test_reset();
		test_program();
		test_io();
		test_general();
		test_priority();
		test_stretch();
		report_and_stop();
	end
endmodule : test_external_chip_select_decoder
